// ### core/cmb_msgbuf_id_ctrl.sv
// message buffer identifiers, status flags, receive candidacy and register port
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module cmb_msgbuf_id_ctrl #(
    parameter int NUM_BUF = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [cmb_pkg::CMB_ADDR_W-1:0] reg_addr,
    input wire logic [cmb_pkg::CMB_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [cmb_pkg::CMB_DATA_W-1:0] reg_rdata,
    input wire logic [cmb_pkg::CMB_ID_W-1:0] rx_identifier,
    input wire logic rx_extended,
    input wire logic rx_remote,
    input wire logic store_start,
    input wire logic store_end,
    input wire logic [$clog2(NUM_BUF)-1:0] store_index,
    input wire logic tx_done,
    input wire logic [$clog2(NUM_BUF)-1:0] tx_index,
    output logic [NUM_BUF-1:0] rx_match,
    output logic [NUM_BUF-1:0] tx_pending,
    output logic rx_irq,
    output logic tx_irq,
    output logic operational,
    output logic module_clock_tick
);
    import cmb_pkg::*;
    localparam int IDX_W = $clog2(NUM_BUF);

    logic [CMB_ID_W-1:0] identifier_bits_reg [NUM_BUF];
    logic [NUM_BUF-1:0] ext_select_reg;
    logic [NUM_BUF-1:0] assigned_reg;
    logic [2:0] type_reg [NUM_BUF];
    logic op_enable_reg;
    logic [CMB_PRESC_W-1:0] presc_reg;
    logic [CMB_DATA_W-1:0] rdata_reg;
    logic [NUM_BUF-1:0] rx_match_reg;
    logic [NUM_BUF-1:0] tx_pending_reg;
    logic rx_irq_reg;
    logic tx_irq_reg;

    logic [NUM_BUF-1:0] updating_w;
    logic [NUM_BUF-1:0] overwrite_w;
    logic [NUM_BUF-1:0] irq_en_w;
    logic [NUM_BUF-1:0] stored_w;
    logic [NUM_BUF-1:0] tx_req_w;
    logic [NUM_BUF-1:0] rdy_w;
    logic [NUM_BUF-1:0] is_rx_w;
    logic [NUM_BUF-1:0] candidate_w;
    logic [NUM_BUF-1:0] id_hit_w;

    logic [7:0] buf_off;
    logic [5:0] buf_sel;
    logic [IDX_W-1:0] buf_idx;
    logic [1:0] buf_sub;
    logic buf_hit;
    logic store_ok;
    logic store_start_ok;
    logic store_end_ok;
    logic tx_done_ok;
    logic [CMB_DATA_W-1:0] read_value;

    assign buf_off = reg_addr - BUF_BASE_ADDR;
    assign buf_sel = buf_off[7:2];
    assign buf_idx = buf_sel[IDX_W-1:0];
    assign buf_sub = buf_off[1:0];
    assign buf_hit = (reg_addr >= BUF_BASE_ADDR) && (buf_sel < 6'(NUM_BUF));

    // storage events count only while operating and only into a ready buffer; completions only while operating
    assign store_ok = op_enable_reg && rdy_w[store_index];
    assign store_start_ok = store_start && store_ok;
    assign store_end_ok = store_end && store_ok;
    assign tx_done_ok = tx_done && op_enable_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g++) begin : g_buf
            logic ctrl_wr;
            logic st_hit;
            assign ctrl_wr = reg_write && buf_hit && (buf_idx == IDX_W'(g))
                && (buf_sub == SUB_CONTROL);
            assign st_hit = store_index == IDX_W'(g);
            assign is_rx_w[g] = (type_reg[g] >= TYPE_RX_FIRST)
                && (type_reg[g] <= TYPE_RX_LAST);
            assign candidate_w[g] = assigned_reg[g] && is_rx_w[g] && rdy_w[g];
            // standard format compares only the upper eleven positions
            assign id_hit_w[g] = (ext_select_reg[g] == rx_extended) && (ext_select_reg[g]
                ? (identifier_bits_reg[g] == rx_identifier)
                : (identifier_bits_reg[g][CMB_ID_W-1 -: CMB_STD_W]
                    == rx_identifier[CMB_ID_W-1 -: CMB_STD_W]));

            cmb_buffer_flags u_flags (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .ctrl_write(ctrl_wr),
                .wdata(reg_wdata),
                .store_start(store_start_ok && st_hit),
                .store_end(store_end_ok && st_hit),
                .store_remote(rx_remote),
                .is_tx(type_reg[g] == TYPE_TX),
                .tx_done(tx_done_ok && (tx_index == IDX_W'(g))),
                .update_in_progress(updating_w[g]),
                .overwrite_status(overwrite_w[g]),
                .buffer_interrupt_enable(irq_en_w[g]),
                .data_stored_flag(stored_w[g]),
                .transmit_request(tx_req_w[g]),
                .ready(rdy_w[g])
            );
        end
    endgenerate

    // identifier and configuration: software only while not ready
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_BUF; i++) begin
                identifier_bits_reg[i] <= '0;
                type_reg[i] <= TYPE_TX;
            end
            ext_select_reg <= '0;
            assigned_reg <= '0;
        end else if (store_start_ok && is_rx_w[store_index]) begin
            // receive buffers keep the identifier received
            identifier_bits_reg[store_index] <= rx_identifier;
            ext_select_reg[store_index] <= rx_extended;
        end else if (reg_write && buf_hit && !rdy_w[buf_idx]) begin
            case (buf_sub)
                SUB_ID_LOW: begin
                    identifier_bits_reg[buf_idx][CMB_DATA_W-1:0] <= reg_wdata;
                end
                SUB_ID_HIGH: begin
                    identifier_bits_reg[buf_idx][CMB_ID_W-1:CMB_DATA_W] <=
                        reg_wdata[IDH_TOP:0];
                    ext_select_reg[buf_idx] <= reg_wdata[EXT_SELECT_BIT];
                end
                SUB_CONFIG: begin
                    type_reg[buf_idx] <= reg_wdata[TYPE_MSB:TYPE_LSB];
                    assigned_reg[buf_idx] <= reg_wdata[ASSIGNED_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            op_enable_reg <= 1'b0;
        end else if (reg_write && reg_addr == GLOBAL_CONTROL_ADDR) begin
            op_enable_reg <= reg_wdata[OP_ENABLE_BIT];
        end
    end

    // prescaler frozen once running so the bit timing cannot shift mid-frame
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            presc_reg <= '0;
        end else if (reg_write && reg_addr == GLOBAL_CLOCK_SELECT_ADDR && !op_enable_reg) begin
            presc_reg <= reg_wdata[CMB_PRESC_W-1:0];
        end
    end

    always_comb begin
        read_value = REG_RESET;
        if (reg_addr == GLOBAL_CONTROL_ADDR) begin
            read_value[OP_ENABLE_BIT] = op_enable_reg;
        end else if (reg_addr == GLOBAL_CLOCK_SELECT_ADDR) begin
            read_value[CMB_PRESC_W-1:0] = presc_reg;
        end else if (buf_hit) begin
            case (buf_sub)
                SUB_ID_LOW: begin
                    read_value = identifier_bits_reg[buf_idx][CMB_DATA_W-1:0];
                end
                SUB_ID_HIGH: begin
                    read_value[IDH_TOP:0] = identifier_bits_reg[buf_idx][CMB_ID_W-1:CMB_DATA_W];
                    read_value[EXT_SELECT_BIT] = ext_select_reg[buf_idx];
                end
                SUB_CONTROL: begin
                    read_value[UPDATING_BIT] = updating_w[buf_idx];
                    read_value[CLR_OVERWRITE_BIT] = overwrite_w[buf_idx];
                    read_value[IRQ_EN_BIT] = irq_en_w[buf_idx];
                    read_value[STORED_BIT] = stored_w[buf_idx];
                    read_value[TX_REQ_BIT] = tx_req_w[buf_idx];
                    read_value[RDY_BIT] = rdy_w[buf_idx];
                end
                default: begin
                    read_value[TYPE_MSB:TYPE_LSB] = type_reg[buf_idx];
                    read_value[ASSIGNED_BIT] = assigned_reg[buf_idx];
                end
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_reg <= REG_RESET;
        end else begin
            rdata_reg <= reg_read ? read_value : REG_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_match_reg <= '0;
            tx_pending_reg <= '0;
        end else begin
            rx_match_reg <= op_enable_reg ? (candidate_w & id_hit_w) : '0;
            tx_pending_reg <= op_enable_reg ? (tx_req_w & rdy_w) : '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_irq_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
        end else begin
            rx_irq_reg <= store_end_ok && irq_en_w[store_index];
            tx_irq_reg <= tx_done_ok && irq_en_w[tx_index]
                && (type_reg[tx_index] == TYPE_TX);
        end
    end

    cmb_clock_divider #(
        .PRESC_W(CMB_PRESC_W)
    ) u_div (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(op_enable_reg),
        .presc(presc_reg),
        .tick(module_clock_tick)
    );

    assign reg_rdata = rdata_reg;
    assign rx_match = rx_match_reg;
    assign tx_pending = tx_pending_reg;
    assign rx_irq = rx_irq_reg;
    assign tx_irq = tx_irq_reg;
    assign operational = op_enable_reg;
endmodule // cmb_msgbuf_id_ctrl

// ### core/cmb_pkg.sv
// constants and register layout of the message buffer identifier and control block
package cmb_pkg;
    localparam int CMB_ADDR_W = 8;
    localparam int CMB_DATA_W = 16;
    localparam int CMB_ID_W = 29;
    localparam int CMB_STD_W = 11;
    localparam int CMB_PRESC_W = 4;
    localparam logic [7:0] GLOBAL_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] GLOBAL_CLOCK_SELECT_ADDR = 8'h01;
    localparam logic [7:0] BUF_BASE_ADDR = 8'h10;
    localparam logic [1:0] SUB_ID_LOW = 2'h0;
    localparam logic [1:0] SUB_ID_HIGH = 2'h1;
    localparam logic [1:0] SUB_CONTROL = 2'h2;
    localparam logic [1:0] SUB_CONFIG = 2'h3;
    localparam int OP_ENABLE_BIT = 0;
    localparam int EXT_SELECT_BIT = 15;
    localparam int IDH_TOP = 12;
    localparam int UPDATING_BIT = 13;
    localparam int SET_IRQ_EN_BIT = 11;
    localparam int SET_TX_REQ_BIT = 9;
    localparam int SET_RDY_BIT = 8;
    localparam int CLR_OVERWRITE_BIT = 4;
    localparam int IRQ_EN_BIT = 3;
    localparam int STORED_BIT = 2;
    localparam int TX_REQ_BIT = 1;
    localparam int RDY_BIT = 0;
    localparam int ASSIGNED_BIT = 0;
    localparam int TYPE_LSB = 3;
    localparam int TYPE_MSB = 5;
    localparam logic [2:0] TYPE_TX = 3'h0;
    localparam logic [2:0] TYPE_RX_FIRST = 3'h1;
    localparam logic [2:0] TYPE_RX_LAST = 3'h5;
    localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

// ### core/cmb_clock_divider.sv
// prescaled module clock enable, running only while the controller operates
`timescale 1ns/1ns
module cmb_clock_divider #(
    parameter int PRESC_W = cmb_pkg::CMB_PRESC_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [PRESC_W-1:0] presc,
    output logic tick
);
    import cmb_pkg::*;
    logic [PRESC_W-1:0] count_reg;
    logic tick_reg;

    // divide by presc+1; restarts from zero whenever operation stops
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !run) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else if (count_reg == presc) begin
            count_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    assign tick = tick_reg;
endmodule // cmb_clock_divider

// ### core/cmb_buffer_flags.sv
// status flags of one message buffer; enable, request and ready take paired set and clear writes
`timescale 1ns/1ns
module cmb_buffer_flags (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ctrl_write,
    input wire logic [cmb_pkg::CMB_DATA_W-1:0] wdata,
    input wire logic store_start,
    input wire logic store_end,
    input wire logic store_remote,
    input wire logic is_tx,
    input wire logic tx_done,
    output logic update_in_progress,
    output logic overwrite_status,
    output logic buffer_interrupt_enable,
    output logic data_stored_flag,
    output logic transmit_request,
    output logic ready
);
    import cmb_pkg::*;
    logic updating_reg;
    logic overwrite_reg;
    logic irq_en_reg;
    logic stored_reg;
    logic tx_req_reg;
    logic rdy_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            updating_reg <= 1'b0;
        end else if (store_start) begin
            updating_reg <= 1'b1;
        end else if (store_end) begin
            updating_reg <= 1'b0;
        end
    end

    // set by storage beats a clear write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overwrite_reg <= 1'b0;
        end else if (store_start && stored_reg && !(store_remote && is_tx)) begin
            overwrite_reg <= 1'b1;
        end else if (ctrl_write && wdata[CLR_OVERWRITE_BIT]) begin
            overwrite_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stored_reg <= 1'b0;
        end else if (store_start || store_end) begin
            stored_reg <= 1'b1;
        end else if (ctrl_write && wdata[STORED_BIT]) begin
            stored_reg <= 1'b0;
        end
    end

    // enable is locked while the buffer belongs to the controller
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_en_reg <= 1'b0;
        end else if (ctrl_write && !rdy_reg) begin
            if (wdata[SET_IRQ_EN_BIT] && !wdata[IRQ_EN_BIT]) begin
                irq_en_reg <= 1'b1;
            end else if (!wdata[SET_IRQ_EN_BIT] && wdata[IRQ_EN_BIT]) begin
                irq_en_reg <= 1'b0;
            end
        end
    end

    // a software set wins over the completion clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_req_reg <= 1'b0;
        end else if (ctrl_write && wdata[SET_TX_REQ_BIT] && !wdata[TX_REQ_BIT]) begin
            tx_req_reg <= 1'b1;
        end else if (ctrl_write && !wdata[SET_TX_REQ_BIT] && wdata[TX_REQ_BIT]) begin
            tx_req_reg <= 1'b0;
        end else if (tx_done) begin
            tx_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdy_reg <= 1'b0;
        end else if (ctrl_write && wdata[SET_RDY_BIT] && !wdata[RDY_BIT]) begin
            rdy_reg <= 1'b1;
        end else if (ctrl_write && !wdata[SET_RDY_BIT] && wdata[RDY_BIT]) begin
            rdy_reg <= 1'b0;
        end
    end

    assign update_in_progress = updating_reg;
    assign overwrite_status = overwrite_reg;
    assign buffer_interrupt_enable = irq_en_reg;
    assign data_stored_flag = stored_reg;
    assign transmit_request = tx_req_reg;
    assign ready = rdy_reg;
endmodule // cmb_buffer_flags

// ### tb/cmb_msgbuf_assertions.sv
// port level checks for the message buffer identifier and control block
`timescale 1ns/1ns
module cmb_msgbuf_assertions #(
    parameter int NUM_BUF = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [cmb_pkg::CMB_ADDR_W-1:0] reg_addr,
    input wire logic [cmb_pkg::CMB_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [cmb_pkg::CMB_DATA_W-1:0] reg_rdata,
    input wire logic store_end,
    input wire logic tx_done,
    input wire logic [$clog2(NUM_BUF)-1:0] tx_index,
    input wire logic [NUM_BUF-1:0] rx_match,
    input wire logic [NUM_BUF-1:0] tx_pending,
    input wire logic rx_irq,
    input wire logic tx_irq,
    input wire logic operational,
    input wire logic module_clock_tick
);
    import cmb_pkg::*;
    logic in_buf;
    logic gc_wr;
    assign in_buf = (reg_addr >= BUF_BASE_ADDR) && (reg_addr < BUF_BASE_ADDR + 4 * NUM_BUF);
    assign gc_wr = reg_write && (reg_addr == GLOBAL_CONTROL_ADDR);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    op_enable_a: assert property (gc_wr |=> operational == $past(reg_wdata[OP_ENABLE_BIT]))
        else $error("operation enable not taken from write");
    op_hold_a: assert property (!gc_wr |=> $stable(operational))
        else $error("operation enable moved without write");
    match_gate_a: assert property (!operational |=> rx_match == '0 && tx_pending == '0)
        else $error("candidate or pending while stopped");
    tick_gate_a: assert property (!operational |=> !module_clock_tick)
        else $error("clock tick while stopped");
    rx_irq_cause_a: assert property (rx_irq |-> $past(store_end) && $past(operational))
        else $error("reception interrupt without storage end");
    tx_irq_cause_a: assert property (tx_irq |-> $past(tx_done) && $past(operational))
        else $error("transmission interrupt without completion");
    tx_clear_a: assert property (
        tx_done && operational && !reg_write |-> ##2 !tx_pending[$past(tx_index, 2)])
        else $error("pending transmission kept after completion");
    ctrl_read_a: assert property (
        reg_read && in_buf && reg_addr[1:0] == SUB_CONTROL |=> (reg_rdata & 16'hDFE0) == 16'h0000)
        else $error("control read shows reserved bits");
    idh_read_a: assert property (
        reg_read && in_buf && reg_addr[1:0] == SUB_ID_HIGH |=> reg_rdata[14:13] == 2'h0)
        else $error("identifier high read shows bits 14 13");
    cover property (rx_irq);
    cover property (tx_irq);
    cover property (module_clock_tick);
endmodule // cmb_msgbuf_assertions

// ### tb/cmb_far_node.sv
// far side model: protocol engine storing frames and completing transmissions
`timescale 1ns/1ns
module cmb_far_node (
    input wire logic sys_clk,
    output logic [cmb_pkg::CMB_ID_W-1:0] rx_identifier,
    output logic rx_extended,
    output logic rx_remote,
    output logic store_start,
    output logic store_end,
    output logic [3:0] store_index,
    output logic tx_done,
    output logic [3:0] tx_index
);
    import cmb_pkg::*;
    initial begin
        rx_identifier = '0;
        rx_extended = 1'b0;
        rx_remote = 1'b0;
        store_start = 1'b0;
        store_end = 1'b0;
        store_index = 4'h0;
        tx_done = 1'b0;
        tx_index = 4'h0;
    end
    task automatic show_id(input logic [28:0] id, input logic ext);
        @(posedge sys_clk);
        rx_identifier <= id;
        rx_extended <= ext;
    endtask
    // storage window opens here and stays open until end_store
    task automatic begin_store(input logic [3:0] idx, input logic [28:0] id, input logic rem);
        @(posedge sys_clk);
        rx_identifier <= id;
        rx_remote <= rem;
        rx_extended <= 1'b0;
        store_index <= idx;
        store_start <= 1'b1;
        @(posedge sys_clk);
        store_start <= 1'b0;
    endtask
    task automatic end_store();
        @(posedge sys_clk);
        store_end <= 1'b1;
        @(posedge sys_clk);
        store_end <= 1'b0;
        // frame gone: old identifier must not linger on the lines
        rx_identifier <= ~rx_identifier;
        rx_remote <= ~rx_remote;
        #1;
    endtask
    task automatic finish_tx(input logic [3:0] idx);
        @(posedge sys_clk);
        tx_index <= idx;
        tx_done <= 1'b1;
        @(posedge sys_clk);
        tx_done <= 1'b0;
        tx_index <= ~idx;
        #1;
    endtask
endmodule // cmb_far_node

// ### tb/tb_top.sv
// self-checking bench for the message buffer identifier and control block
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    import cmb_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [28:0] rx_identifier;
    logic rx_extended, rx_remote, store_start, store_end, tx_done;
    logic [3:0] store_index, tx_index;
    logic [15:0] rx_match, tx_pending;
    logic rx_irq, tx_irq, operational, module_clock_tick;
    int failures = 0;
    int check_count = 0;
    logic [15:0] cw [14] = '{16'h0800, 16'h0808, 16'h0008, 16'h0800, 16'h0100, 16'h0000,
        16'h0101, 16'h0200, 16'h0202, 16'h0008, 16'h0400, 16'h0002, 16'h0001, 16'h0008};
    logic [15:0] cr [14] = '{16'h0008, 16'h0008, 16'h0000, 16'h0008, 16'h0009, 16'h0009,
        16'h0009, 16'h000B, 16'h000B, 16'h000B, 16'h000B, 16'h0009, 16'h0008, 16'h0000};
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    cmb_msgbuf_id_ctrl u_cmb_msgbuf_id_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_identifier(rx_identifier),
        .rx_extended(rx_extended), .rx_remote(rx_remote), .store_start(store_start),
        .store_end(store_end), .store_index(store_index), .tx_done(tx_done),
        .tx_index(tx_index), .rx_match(rx_match), .tx_pending(tx_pending),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .operational(operational),
        .module_clock_tick(module_clock_tick));
    cmb_far_node u_cmb_far_node (.sys_clk(sys_clk), .rx_identifier(rx_identifier),
        .rx_extended(rx_extended), .rx_remote(rx_remote), .store_start(store_start),
        .store_end(store_end), .store_index(store_index), .tx_done(tx_done),
        .tx_index(tx_index));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic t_reset();
        rd(GLOBAL_CONTROL_ADDR, 16'h0000);
        rd(8'h12, 16'h0000);
        rd(8'hFF, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        // ready set alone before request, enable alone before ready
        for (int i = 0; i < 14; i++) begin
            wr(8'h12, cw[i]);
            rd(8'h12, cr[i]);
        end
        $display("test control done");
    endtask
    task automatic t_ids();
        wr(8'h1D, 16'h9FFF);
        wr(8'h1C, 16'hA5C3);
        rd(8'h1D, 16'h9FFF);
        wr(8'h1E, 16'h0100);
        wr(8'h1C, 16'h0000);
        rd(8'h1C, 16'hA5C3);
        wr(8'h1E, 16'h0001);
        rd(8'h1E, 16'h0000);
        $display("test identifiers done");
    endtask
    task automatic t_enable();
        int n;
        n = 0;
        for (int i = 0; i < 16; i++) begin
            wr(8'(BUF_BASE_ADDR + 4 * i + SUB_CONTROL), 16'h0007);
        end
        wr(GLOBAL_CLOCK_SELECT_ADDR, 16'h0002);
        wr(GLOBAL_CONTROL_ADDR, 16'h0001);
        rd(GLOBAL_CONTROL_ADDR, 16'h0001);
        `CHK(operational, 1'b1)
        wr(GLOBAL_CLOCK_SELECT_ADDR, 16'h0000);
        rd(GLOBAL_CLOCK_SELECT_ADDR, 16'h0002);
        repeat (30) begin
            @(posedge sys_clk);
            #1 n += module_clock_tick;
        end
        `CHK(n, 10)
        $display("test enable done");
    endtask
    task automatic t_rx();
        wr(8'h1B, 16'h0009);
        wr(8'h19, 16'h048C);
        wr(8'h1A, 16'h0800);
        u_cmb_far_node.show_id({11'h123, 18'h2AAAA}, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(rx_match[2], 1'b0)
        wr(8'h1A, 16'h0100);
        u_cmb_far_node.show_id({11'h123, 18'h2AAAA}, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(rx_match[2], 1'b1)
        u_cmb_far_node.show_id({11'h123, 18'h2AAAA}, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(rx_match[2], 1'b0)
        u_cmb_far_node.begin_store(4'h2, {11'h123, 18'h0}, 1'b0);
        rd(8'h1A, 16'h200D);
        u_cmb_far_node.end_store();
        `CHK(rx_irq, 1'b1)
        rd(8'h1A, 16'h000D);
        u_cmb_far_node.begin_store(4'h2, {11'h123, 18'h0}, 1'b0);
        u_cmb_far_node.end_store();
        rd(8'h1A, 16'h001D);
        wr(8'h1A, 16'h0014);
        rd(8'h1A, 16'h0009);
        $display("test reception done");
    endtask
    task automatic t_tx();
        wr(8'h16, 16'h0800);
        wr(8'h16, 16'h0100);
        wr(8'h16, 16'h0200);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(tx_pending[1], 1'b1)
        repeat (2) begin
            u_cmb_far_node.begin_store(4'h1, 29'h0, 1'b1);
            u_cmb_far_node.end_store();
        end
        rd(8'h16, 16'h000F);
        u_cmb_far_node.finish_tx(4'h1);
        `CHK(tx_irq, 1'b1)
        rd(8'h16, 16'h000D);
        wr(8'h16, 16'h0001);
        wr(8'h16, 16'h0008);
        wr(8'h16, 16'h0100);
        wr(8'h16, 16'h0200);
        u_cmb_far_node.finish_tx(4'h1);
        `CHK(tx_irq, 1'b0)
        $display("test transmission done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_ctrl();
        t_ids();
        t_enable();
        t_rx();
        t_tx();
        tally_and_finish();
    end
    initial begin
        #(50 * 3000);
        failures++;
        tally_and_finish();
    end
endmodule // tb_top
bind cmb_msgbuf_id_ctrl cmb_msgbuf_assertions #(.NUM_BUF(NUM_BUF)) u_cmb_msgbuf_assertions (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .store_end(store_end), .tx_done(tx_done), .tx_index(tx_index), .rx_match(rx_match),
    .tx_pending(tx_pending), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .operational(operational), .module_clock_tick(module_clock_tick));
